// ---- hdl/cpr_pkg.sv ----
// shared constants and types for the charger power-path register bank
package cpr_pkg;

  // register offsets on the serial bus
  localparam logic [7:0] CTRL_ADDR = 8'h0F;
  localparam logic [7:0] FLOAT_ADDR = 8'h11;

  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h40;
  localparam logic [7:0] FLOAT_RST = 8'h68;

  // field positions in power_path_control
  localparam int SOFT_RESET_BIT = 7;
  localparam int THERM_HI_BIT = 6;
  localparam int THERM_LO_BIT = 5;
  localparam int ARM_BIT = 2;
  localparam int OFF_BIT = 1;
  localparam int CDIS_BIT = 0;

  // bits that hold storage; soft reset and reserved bits are not stored
  localparam logic [7:0] CTRL_STORE_MASK = 8'h67;

  // thermal threshold decode in degrees C
  localparam logic [6:0] THERM_C_70 = 7'h46;
  localparam logic [6:0] THERM_C_85 = 7'h55;
  localparam logic [6:0] THERM_C_100 = 7'h64;
  localparam logic [6:0] THERM_C_120 = 7'h78;

  // float voltage: code 0x0E is 4400 mV, 10 mV per code
  localparam logic [12:0] FLOAT_MV_BASE = 13'h10A4;
  localparam logic [12:0] FLOAT_MV_STEP = 13'h000A;

  // bits per serial byte
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // serial slave states
  typedef enum logic [3:0] {
    CPR_IDLE,
    CPR_ADDR,
    CPR_ACK_ADDR,
    CPR_PTR,
    CPR_ACK_PTR,
    CPR_WDATA,
    CPR_ACK_WR,
    CPR_RDATA,
    CPR_RD_ACK
  } cpr_i2c_state_t;

endpackage

// ---- hdl/cpr_power_path_regs.sv ----
// charger power-path control and float voltage registers behind a serial slave
module cpr_power_path_regs #(
  // slave address; value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h35
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic i2c_scl_i,
  input wire logic i2c_sda_i,
  output logic i2c_sda_o,
  output logic i2c_sda_oe,
  input wire logic vbus_valid,
  input wire logic vin_valid,
  input wire logic sys_below_bat,
  output logic [1:0] thermal_regulation_threshold,
  output logic [6:0] threshold_celsius,
  output logic ship_mode_arm,
  output logic battery_switch_off,
  output logic charge_disable,
  output logic [7:0] float_voltage_target,
  output logic [12:0] float_voltage_mv,
  output logic battery_path_switch_on,
  output logic supplement_allowed
);

  typedef struct packed {
    cpr_pkg::cpr_i2c_state_t st;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic rw;
    logic mack;
    logic [7:0] ptr;
    logic sda_oe;
    logic scl_prev;
    logic sda_prev;
    logic vbus_prev;
    logic vin_prev;
    logic [7:0] ctrl;
    logic [7:0] flt;
    logic [6:0] temp_c;
    logic [12:0] float_mv;
    logic sw_on;
    logic supp_ok;
  } cpr_state_t;

  localparam cpr_state_t ST_RST = '{
    st: cpr_pkg::CPR_IDLE,
    shift: 8'h00,
    cnt: 4'h0,
    rw: 1'b0,
    mack: 1'b0,
    ptr: 8'h00,
    sda_oe: 1'b0,
    scl_prev: 1'b0,
    sda_prev: 1'b0,
    vbus_prev: 1'b0,
    vin_prev: 1'b0,
    ctrl: cpr_pkg::CTRL_RST,
    flt: cpr_pkg::FLOAT_RST,
    temp_c: cpr_pkg::THERM_C_100,
    float_mv: 13'(cpr_pkg::FLOAT_MV_BASE + 13'(cpr_pkg::FLOAT_RST) * cpr_pkg::FLOAT_MV_STEP),
    sw_on: 1'b1,
    supp_ok: 1'b1
  };

  cpr_state_t r_ff;
  cpr_state_t nxt_r;
  logic [4:0] sync_q;

  cpr_sync #(
    .W(5)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .d({sys_below_bat, vin_valid, vbus_valid, i2c_sda_i, i2c_scl_i}),
    .q(sync_q)
  );

  // read mux
  function automatic logic [7:0] rd_byte(input logic [7:0] addr, input logic [7:0] ctrl, input logic [7:0] flt);
    logic [7:0] v;
    v = 8'h00;
    if (addr == cpr_pkg::CTRL_ADDR) begin
      v = ctrl & cpr_pkg::CTRL_STORE_MASK;
    end else if (addr == cpr_pkg::FLOAT_ADDR) begin
      v = flt;
    end
    return v;
  endfunction

  logic scl;
  logic sda;
  logic vbus;
  logic vin;
  logic sys_low;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic wr_ctrl;
  logic wr_float;
  logic [7:0] wdata;
  logic [7:0] rbyte;
  logic src_now;
  logic src_prev;
  logic src_rise;
  logic src_fall;
  logic hw_set_off;
  logic clr_ship;
  logic clr_off;
  logic wr_arm_one;
  logic wr_off_one;

  always_comb begin
    nxt_r = r_ff;
    scl = sync_q[0];
    sda = sync_q[1];
    vbus = sync_q[2];
    vin = sync_q[3];
    sys_low = sync_q[4];
    nxt_r.scl_prev = scl;
    nxt_r.sda_prev = sda;
    nxt_r.vbus_prev = vbus;
    nxt_r.vin_prev = vin;
    scl_rise = scl & ~r_ff.scl_prev;
    scl_fall = ~scl & r_ff.scl_prev;
    bus_start = scl & r_ff.scl_prev & r_ff.sda_prev & ~sda;
    bus_stop = scl & r_ff.scl_prev & ~r_ff.sda_prev & sda;
    wr_ctrl = 1'b0;
    wr_float = 1'b0;
    wdata = r_ff.shift;
    rbyte = rd_byte(r_ff.ptr, r_ff.ctrl, r_ff.flt);

    // serial slave: registers reached only by byte transfers
    if (bus_start) begin
      nxt_r.st = cpr_pkg::CPR_ADDR;
      nxt_r.cnt = 4'h0;
      nxt_r.sda_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_r.st = cpr_pkg::CPR_IDLE;
      nxt_r.sda_oe = 1'b0;
    end else begin
      unique case (r_ff.st)
        cpr_pkg::CPR_IDLE: begin
          nxt_r.sda_oe = 1'b0;
        end
        cpr_pkg::CPR_ADDR, cpr_pkg::CPR_PTR, cpr_pkg::CPR_WDATA: begin
          if (scl_rise && r_ff.cnt != cpr_pkg::BYTE_BITS) begin
            nxt_r.shift = {r_ff.shift[6:0], sda};
            nxt_r.cnt = 4'(r_ff.cnt + 4'h1);
          end
          if (scl_fall && r_ff.cnt == cpr_pkg::BYTE_BITS) begin
            nxt_r.cnt = 4'h0;
            if (r_ff.st == cpr_pkg::CPR_ADDR) begin
              if (r_ff.shift[7:1] == DEV_ADDR) begin
                nxt_r.rw = r_ff.shift[0];
                nxt_r.sda_oe = 1'b1;
                nxt_r.st = cpr_pkg::CPR_ACK_ADDR;
              end else begin
                nxt_r.st = cpr_pkg::CPR_IDLE;
              end
            end else if (r_ff.st == cpr_pkg::CPR_PTR) begin
              nxt_r.ptr = r_ff.shift;
              nxt_r.sda_oe = 1'b1;
              nxt_r.st = cpr_pkg::CPR_ACK_PTR;
            end else begin
              wr_ctrl = (r_ff.ptr == cpr_pkg::CTRL_ADDR);
              wr_float = (r_ff.ptr == cpr_pkg::FLOAT_ADDR);
              nxt_r.ptr = 8'(r_ff.ptr + 8'h01);
              nxt_r.sda_oe = 1'b1;
              nxt_r.st = cpr_pkg::CPR_ACK_WR;
            end
          end
        end
        cpr_pkg::CPR_ACK_ADDR: begin
          if (scl_fall) begin
            if (r_ff.rw) begin
              nxt_r.shift = rbyte;
              nxt_r.sda_oe = ~rbyte[7];
              nxt_r.cnt = 4'h1;
              nxt_r.st = cpr_pkg::CPR_RDATA;
            end else begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.st = cpr_pkg::CPR_PTR;
            end
          end
        end
        cpr_pkg::CPR_ACK_PTR, cpr_pkg::CPR_ACK_WR: begin
          if (scl_fall) begin
            nxt_r.sda_oe = 1'b0;
            nxt_r.st = cpr_pkg::CPR_WDATA;
          end
        end
        cpr_pkg::CPR_RDATA: begin
          if (scl_fall) begin
            if (r_ff.cnt == cpr_pkg::BYTE_BITS) begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.ptr = 8'(r_ff.ptr + 8'h01);
              nxt_r.st = cpr_pkg::CPR_RD_ACK;
            end else begin
              nxt_r.shift = {r_ff.shift[6:0], 1'b0};
              nxt_r.sda_oe = ~r_ff.shift[6];
              nxt_r.cnt = 4'(r_ff.cnt + 4'h1);
            end
          end
        end
        cpr_pkg::CPR_RD_ACK: begin
          if (scl_rise) begin
            nxt_r.mack = ~sda;
          end
          if (scl_fall) begin
            if (r_ff.mack) begin
              nxt_r.shift = rbyte;
              nxt_r.sda_oe = ~rbyte[7];
              nxt_r.cnt = 4'h1;
              nxt_r.st = cpr_pkg::CPR_RDATA;
            end else begin
              nxt_r.st = cpr_pkg::CPR_IDLE;
            end
          end
        end
      endcase
    end

    // input source events
    src_now = vbus | vin;
    src_prev = r_ff.vbus_prev | r_ff.vin_prev;
    src_rise = src_now & ~src_prev;
    src_fall = ~src_now & src_prev;
    hw_set_off = r_ff.ctrl[cpr_pkg::ARM_BIT] & ((~vbus & r_ff.vbus_prev) | (~vin & r_ff.vin_prev));
    clr_ship = r_ff.ctrl[cpr_pkg::ARM_BIT] & src_rise;
    clr_off = clr_ship | (~r_ff.ctrl[cpr_pkg::ARM_BIT] & (src_rise | src_fall));
    wr_arm_one = wr_ctrl & wdata[cpr_pkg::ARM_BIT];
    wr_off_one = wr_ctrl & wdata[cpr_pkg::OFF_BIT];

    // host writes; reserved and soft reset bits are not stored
    if (wr_ctrl) begin
      nxt_r.ctrl = wdata & cpr_pkg::CTRL_STORE_MASK;
    end
    if (wr_float) begin
      nxt_r.flt = wdata;
    end

    // hardware clears lose to a same-cycle set
    if (clr_ship && !wr_arm_one) begin
      nxt_r.ctrl[cpr_pkg::ARM_BIT] = 1'b0;
    end
    nxt_r.ctrl[cpr_pkg::OFF_BIT] = (nxt_r.ctrl[cpr_pkg::OFF_BIT] & ~clr_off) | hw_set_off | wr_off_one;

    // soft reset restores every register
    if (wr_ctrl && wdata[cpr_pkg::SOFT_RESET_BIT]) begin
      nxt_r.ctrl = cpr_pkg::CTRL_RST;
      nxt_r.flt = cpr_pkg::FLOAT_RST;
    end

    // thermal threshold decode
    unique case (nxt_r.ctrl[cpr_pkg::THERM_HI_BIT:cpr_pkg::THERM_LO_BIT])
      2'h0: nxt_r.temp_c = cpr_pkg::THERM_C_70;
      2'h1: nxt_r.temp_c = cpr_pkg::THERM_C_85;
      2'h2: nxt_r.temp_c = cpr_pkg::THERM_C_100;
      2'h3: nxt_r.temp_c = cpr_pkg::THERM_C_120;
    endcase

    // float voltage target in mV
    nxt_r.float_mv = 13'(cpr_pkg::FLOAT_MV_BASE + 13'(nxt_r.flt) * cpr_pkg::FLOAT_MV_STEP);

    // battery path switch and supplement permission
    nxt_r.sw_on = ~nxt_r.ctrl[cpr_pkg::OFF_BIT] & (~nxt_r.ctrl[cpr_pkg::CDIS_BIT] | sys_low);
    nxt_r.supp_ok = ~nxt_r.ctrl[cpr_pkg::OFF_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r_ff <= ST_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign i2c_sda_o = 1'b0;
  assign i2c_sda_oe = r_ff.sda_oe;
  assign thermal_regulation_threshold = r_ff.ctrl[cpr_pkg::THERM_HI_BIT:cpr_pkg::THERM_LO_BIT];
  assign threshold_celsius = r_ff.temp_c;
  assign ship_mode_arm = r_ff.ctrl[cpr_pkg::ARM_BIT];
  assign battery_switch_off = r_ff.ctrl[cpr_pkg::OFF_BIT];
  assign charge_disable = r_ff.ctrl[cpr_pkg::CDIS_BIT];
  assign float_voltage_target = r_ff.flt;
  assign float_voltage_mv = r_ff.float_mv;
  assign battery_path_switch_on = r_ff.sw_on;
  assign supplement_allowed = r_ff.supp_ok;

endmodule // cpr_power_path_regs

// ---- hdl/cpr_sync.sv ----
// two-flop synchroniser for asynchronous inputs
module cpr_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cpr_sync_t;

  cpr_sync_t r_ff;
  cpr_sync_t nxt_r;

  // first stage feeds only the second stage
  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = d;
    nxt_r.s2 = r_ff.s1;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign q = r_ff.s2;

endmodule // cpr_sync

// ---- sim/cpr_host_model.sv ----
// serial bus host model for the register bank
module cpr_host_model #(
  parameter logic [6:0] ADDR = 7'h35
) (
  input wire logic core_clk,
  input wire logic dev_oe,
  input wire logic dev_o,
  output logic scl,
  output logic sda_w
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  assign sda_w = drv & (dev_oe ? dev_o : 1'b1);
  task automatic hw(input logic c, input logic d);
    @(posedge core_clk);
    scl <= c;
    drv <= d;
    repeat (7) @(posedge core_clk);
  endtask
  task automatic bit1(input logic b, output logic s);
    hw(1'b0, b);
    hw(1'b1, b);
    s = sda_w;
    hw(1'b0, b);
  endtask
  task automatic start();
    hw(1'b0, 1'b1);
    hw(1'b1, 1'b1);
    hw(1'b1, 1'b0);
    hw(1'b0, 1'b0);
  endtask
  task automatic stop();
    hw(1'b0, 1'b0);
    hw(1'b1, 1'b0);
    hw(1'b1, 1'b1);
  endtask
  // whole bytes, msb first, then the ack slot
  task automatic xfer(input logic [7:0] v, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit1(v[i], s);
      r = {r[6:0], s};
    end
    bit1(1'b1, s);
    ack = ~s;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k1, k2, k3;
    start();
    xfer({a, 1'b0}, r, k1);
    xfer(p, r, k2);
    xfer(d, r, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic k;
    start();
    xfer({ADDR, 1'b0}, d, k);
    xfer(p, d, k);
    start();
    xfer({ADDR, 1'b1}, d, k);
    xfer(8'hFF, d, k);
    stop();
  endtask
  // read byte followed by a master ack so the next byte follows
  task automatic rd_ack_byte(output logic [7:0] r);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit1(1'b1, s);
      r = {r[6:0], s};
    end
    bit1(1'b0, s);
  endtask
  // two-byte read, pointer advances between bytes
  task automatic rd2(input logic [7:0] p, output logic [7:0] d0, output logic [7:0] d1);
    logic k;
    start();
    xfer({ADDR, 1'b0}, d1, k);
    xfer(p, d1, k);
    start();
    xfer({ADDR, 1'b1}, d1, k);
    rd_ack_byte(d0);
    xfer(8'hFF, d1, k);
    stop();
  endtask
endmodule // cpr_host_model

// ---- sim/cpr_power_path_regs_checker.sv ----
// port assertions for the power-path register bank
module cpr_power_path_regs_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic i2c_sda_oe,
  input wire logic [1:0] thermal_regulation_threshold,
  input wire logic [6:0] threshold_celsius,
  input wire logic ship_mode_arm,
  input wire logic battery_switch_off,
  input wire logic charge_disable,
  input wire logic [7:0] float_voltage_target,
  input wire logic [12:0] float_voltage_mv,
  input wire logic battery_path_switch_on,
  input wire logic supplement_allowed
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEGC [4] = '{7'h46, 7'h55, 7'h64, 7'h78};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  a_supp_tracks_off: assert property (supplement_allowed == !battery_switch_off)
    else $error("supplement wrong");
  a_off_blocks_switch: assert property (battery_switch_off |-> !battery_path_switch_on)
    else $error("switch on while off");
  a_enable_switch: assert property (!battery_switch_off && !charge_disable |-> battery_path_switch_on)
    else $error("switch not enabled");
  a_thresh_decode: assert property ($stable(thermal_regulation_threshold) ##1
    $stable(thermal_regulation_threshold) |-> threshold_celsius == DEGC[thermal_regulation_threshold])
    else $error("threshold decode wrong");
  a_mv_map: assert property (float_voltage_mv == 13'h10A4 + 13'(float_voltage_target) * 13'h000A)
    else $error("float mv wrong");
  a_cdis_by_host: assert property ($changed(charge_disable) |-> $rose(i2c_sda_oe))
    else $error("charge disable moved alone");
  a_float_by_host: assert property ($changed(float_voltage_target) |-> $rose(i2c_sda_oe))
    else $error("float moved alone");
  a_off_set_cause: assert property ($rose(battery_switch_off) |-> $past(ship_mode_arm) || $rose(i2c_sda_oe))
    else $error("switch off set without cause");
  a_ack_stands: assert property ($rose(i2c_sda_oe) |-> i2c_sda_oe [*6])
    else $error("data drive too short");
endmodule // cpr_power_path_regs_checker

bind cpr_power_path_regs cpr_power_path_regs_checker i_chk (
  .core_clk(core_clk), .reset_n(reset_n), .i2c_sda_oe(i2c_sda_oe),
  .thermal_regulation_threshold(thermal_regulation_threshold), .threshold_celsius(threshold_celsius),
  .ship_mode_arm(ship_mode_arm), .battery_switch_off(battery_switch_off), .charge_disable(charge_disable),
  .float_voltage_target(float_voltage_target), .float_voltage_mv(float_voltage_mv),
  .battery_path_switch_on(battery_path_switch_on), .supplement_allowed(supplement_allowed)
);

// ---- sim/cpr_power_path_regs_tb_top.sv ----
// self-checking bench for the power-path register bank
module cpr_power_path_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h35;
  localparam logic [6:0] DEGC [4] = '{7'h46, 7'h55, 7'h64, 7'h78};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic vbus_valid = 1'b1;
  logic vin_valid = 1'b0;
  logic sys_below_bat = 1'b0;
  logic scl, sda_w, sda_oe, sda_o, off, arm, cdis, sw_on, supp, ok;
  logic [1:0] th;
  logic [6:0] degc;
  logic [7:0] fv, r, r2;
  logic [12:0] mv;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  always #10 core_clk = ~core_clk;
  cpr_power_path_regs #(.DEV_ADDR(DEV)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .i2c_scl_i(scl), .i2c_sda_i(sda_w),
    .i2c_sda_o(sda_o), .i2c_sda_oe(sda_oe), .vbus_valid(vbus_valid), .vin_valid(vin_valid),
    .sys_below_bat(sys_below_bat), .thermal_regulation_threshold(th), .threshold_celsius(degc),
    .ship_mode_arm(arm), .battery_switch_off(off), .charge_disable(cdis),
    .float_voltage_target(fv), .float_voltage_mv(mv), .battery_path_switch_on(sw_on),
    .supplement_allowed(supp)
  );
  cpr_host_model #(.ADDR(DEV)) i_host (
    .core_clk(core_clk), .dev_oe(sda_oe), .dev_o(sda_o), .scl(scl), .sda_w(sda_w)
  );
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrc(input logic [7:0] p, input logic [7:0] d);
    i_host.wr(DEV, p, d, ok);
    cmp(ok, 1'b1);
  endtask
  task automatic rdc(input logic [7:0] p, input logic [7:0] e);
    i_host.rd(p, r);
    cmp(r, e);
  endtask
  task automatic src(input logic vb, input logic vi, input logic sb);
    @(posedge core_clk);
    vbus_valid <= vb;
    vin_valid <= vi;
    sys_below_bat <= sb;
    repeat (8) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    cmp({th, degc, arm, off, cdis, sw_on, supp}, {2'h2, 7'h64, 5'h03});
    cmp({fv, mv}, {8'h68, 13'h14B4});
    rdc(8'h0F, 8'h40);
    rdc(8'h11, 8'h68);
    for (int i = 0; i < 4; i++) begin
      wrc(8'h0F, {1'b0, 2'(i), 5'h00});
      cmp({th, degc}, {2'(i), DEGC[i]});
    end
    wrc(8'h0F, 8'h7F);
    rdc(8'h0F, 8'h67);
    cmp({arm, off, cdis, sw_on, supp}, 5'h1C);
    wrc(8'h11, 8'h0E);
    cmp({fv, mv}, {8'h0E, 13'h1130});
    wrc(8'h11, 8'h0F);
    cmp({fv, mv}, {8'h0F, 13'h113A});
    wrc(8'h0F, 8'h80);
    rdc(8'h0F, 8'h40);
    rdc(8'h11, 8'h68);
    i_host.rd2(8'h10, r, r2);
    cmp({r, r2}, {8'h00, 8'h68});
    wrc(8'h20, 8'h55);
    rdc(8'h20, 8'h00);
    i_host.wr(7'h12, 8'h0F, 8'h02, ok);
    cmp({ok, off}, 2'h0);
    wrc(8'h0F, 8'h04);
    src(1'b0, 1'b0, 1'b0);
    cmp({arm, off, supp}, 3'h6);
    src(1'b0, 1'b1, 1'b0);
    cmp({arm, off, supp}, 3'h1);
    wrc(8'h0F, 8'h02);
    cmp({off, sw_on, supp}, 3'h4);
    src(1'b0, 1'b0, 1'b0);
    cmp(off, 1'b0);
    wrc(8'h0F, 8'h02);
    src(1'b1, 1'b0, 1'b0);
    cmp(off, 1'b0);
    wrc(8'h0F, 8'h01);
    cmp({sw_on, supp}, 2'h1);
    src(1'b1, 1'b0, 1'b1);
    cmp({sw_on, supp}, 2'h3);
    wrc(8'h0F, 8'h00);
    src(1'b1, 1'b0, 1'b0);
    cmp(sw_on, 1'b1);
    tally_and_finish();
  end
endmodule // cpr_power_path_regs_tb_top
